// File: hw/tsc_pkg.sv
package tsc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry: register index = printed offset, byte address = 4 * index
  localparam int          ADDR_W       = 16;
  localparam int          IDX_W        = 14;
  localparam logic [13:0] IDX_STATUS   = 14'h0420;
  localparam logic [13:0] IDX_CONFIG   = 14'h0422;
  localparam logic [13:0] IDX_S1_NSL   = 14'h0424;
  localparam logic [13:0] IDX_S1_NSH   = 14'h0426;
  localparam logic [13:0] IDX_S1_SL    = 14'h0428;
  localparam logic [13:0] IDX_S1_SH    = 14'h042A;
  localparam logic [13:0] IDX_S1_SUB   = 14'h042C;
  localparam logic [13:0] IDX_CTRL     = 14'h042E;
  localparam logic [13:0] IDX_S2_NSL   = 14'h0434;
  localparam logic [13:0] IDX_S2_NSH   = 14'h0436;
  localparam logic [13:0] IDX_S2_SL    = 14'h0438;
  localparam logic [13:0] IDX_S2_SH    = 14'h043A;
  localparam logic [13:0] IDX_S2_SUB   = 14'h043C;

  //////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          STAT_OVF_BIT = 0;
  localparam int          STAT_CNT_LSB = 1;
  localparam int          NSH_EDGE_BIT = 14;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_RST_BIT = 1;
  localparam logic [11:0] CFG_RESET    = 12'h000;
  localparam logic [3:0]  PIN_SEL_MAX  = 4'hB;
  localparam logic [3:0]  UNIT_SEL_MAX = 4'hB;
  localparam logic [3:0]  CNT_MAX      = 4'hF;
  localparam logic [3:0]  CASC_MAX     = 4'h2;
  localparam logic [2:0]  SUB_MAX      = 3'h4;

  // time base figures, informational: one tick of the time of day
  localparam int          NS_PER_TICK  = 40;
  localparam int          SUB_SLOT_NS  = 8;

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
    logic [2:0]  sub;
  } tsc_time_t;

  typedef struct packed {
    logic      rising;
    tsc_time_t t;
  } tsc_sample_t;

  // packed order matches config word bits 11..0
  typedef struct packed {
    logic [3:0] pin_sel;
    logic       rise_en;
    logic       fall_en;
    logic       tail;
    logic [3:0] up_sel;
    logic       casc_en;
  } tsc_cfg_t;

endpackage : tsc_pkg

// File: hw/tsc_capture_unit.sv
// Operation
// RULE1 - pin select field picks one of twelve pins
// RULE2 - rising edge enable gates rising events
// RULE3 - falling edge enable gates falling events
// RULE4 - tail bit marks final unit of chain
// RULE5 - upstream select chooses done input source
// RULE6 - cascade enable bit joins the chain
// RULE7 - report first event nanoseconds low word
// RULE8 - nanoseconds high word, bit 15 zero
// RULE9 - high word bit 14 gives edge polarity
// RULE10 - report first event seconds low word
// RULE11 - report first event seconds high word
// RULE12 - sub-cycle slot code zero to four
// RULE13 - second event kept in second word set
// RULE14 - count saturates at fifteen, tail sets overflow
// RULE15 - detect edges up to 25 MHz rate
// RULE16 - latch time and edge into free slot
`timescale 1ns/100ps
module tsc_capture_unit #(
  parameter logic [3:0] UNIT_INDEX = 4'h0,
  parameter int         PIN_COUNT  = 12
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [tsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [PIN_COUNT-1:0]     gpio_in,
  input  wire tsc_pkg::tsc_time_t       tod,
  input  wire logic [11:0]              casc_done_in,
  output logic                          casc_done_out
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // one 16-bit view of a sample set; w is the word number 0..4
  function automatic logic [15:0] sample_word(input tsc_pkg::tsc_sample_t s,
                                              input logic [2:0] w);
    logic [15:0] r;
    r = 16'h0000;
    unique case (w)
      3'h0: r = s.t.ns[15:0];                                   // [RULE7]
      3'h1: r = {1'b0, s.rising, s.t.ns[29:16]};                // [RULE8] [RULE9]
      3'h2: r = s.t.sec[15:0];                                  // [RULE10]
      3'h3: r = s.t.sec[31:16];                                 // [RULE11]
      3'h4: r = {13'h0000, s.t.sub};                            // [RULE12]
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : sample_word

  // level of the selected pin; codes past the last pin select nothing
  function automatic logic pin_level(input logic [PIN_COUNT-1:0] pins,
                                     input logic [3:0] sel);
    logic r;
    r = 1'b0;
    if (sel <= tsc_pkg::PIN_SEL_MAX && 32'(sel) < PIN_COUNT) begin
      r = pins[sel];
    end
    return r;
  endfunction : pin_level

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [13:0]          idx;
  logic                 setup_ph;
  logic                 wr_acc;
  logic                 wr_cfg;
  logic                 wr_ctrl;
  logic                 sw_rst;
  logic                 clr_cnt;
  logic                 clr_ovf;

  assign idx      = paddr[15:2];
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && (paddr[1:0] == 2'b00);
  assign wr_cfg   = wr_acc && (idx == tsc_pkg::IDX_CONFIG);
  assign wr_ctrl  = wr_acc && (idx == tsc_pkg::IDX_CTRL);
  assign sw_rst   = wr_ctrl && pwdata[tsc_pkg::CTRL_RST_BIT];
  // writing enable high restarts counting, writing it low drops overflow
  assign clr_cnt  = wr_ctrl && pwdata[tsc_pkg::CTRL_EN_BIT];
  assign clr_ovf  = wr_ctrl && !pwdata[tsc_pkg::CTRL_EN_BIT];
  // every register answers at once; no wait states
  assign pready   = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // configuration and enable
  tsc_pkg::tsc_cfg_t    cfg_q;
  logic                 en_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= tsc_pkg::CFG_RESET;
    end else if (sw_rst) begin
      cfg_q <= tsc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= pwdata[11:0];                                    // [RULE1] [RULE4] [RULE5] [RULE6]
    end
  end

  cfg_write_a: assert property (wr_cfg && !sw_rst |=> cfg_q == $past(pwdata[11:0])) // [RULE1]
    else $error("config word not stored");

  // unit enable, cleared by the software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (sw_rst) begin
      en_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q <= pwdata[tsc_pkg::CTRL_EN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on the selected pin
  logic                 pin_now;
  logic                 pin_prev_q;
  logic                 rise_ev;
  logic                 fall_ev;

  assign pin_now = pin_level(gpio_in, cfg_q.pin_sel);           // [RULE1]

  // a pin change of select can look like one edge; re-arm after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_now;
    end
  end

  // pclk is ten times the 25 MHz event rate, so every edge is seen
  assign rise_ev = pin_now && !pin_prev_q && cfg_q.rise_en;     // [RULE2] [RULE15]
  assign fall_ev = !pin_now && pin_prev_q && cfg_q.fall_en;     // [RULE3] [RULE15]

  //////////////////////////////////////////////////////////////////////////////
  // cascade arming
  logic                 is_head;
  logic                 up_done;
  logic                 armed;
  logic                 non_tail;
  logic [3:0]           cnt_q;
  logic                 done_q;
  logic                 hit;
  logic [3:0]           cnt_base;
  logic [3:0]           cnt_d;

  // a head unit names itself as upstream and needs no done input
  assign is_head  = cfg_q.up_sel == UNIT_INDEX;                 // [RULE5]
  assign up_done  = (cfg_q.up_sel <= tsc_pkg::UNIT_SEL_MAX) && casc_done_in[cfg_q.up_sel];
  assign armed    = en_q && (!cfg_q.casc_en || is_head || up_done); // [RULE6]
  assign non_tail = cfg_q.casc_en && !cfg_q.tail;               // [RULE4]
  assign hit      = (rise_ev || fall_ev) && armed && !done_q;

  //////////////////////////////////////////////////////////////////////////////
  // event count; an event in the clearing cycle still counts
  always_comb begin
    cnt_base = clr_cnt ? 4'h0 : cnt_q;
    cnt_d    = cnt_base;
    if (hit && cnt_base != tsc_pkg::CNT_MAX) begin
      cnt_d = cnt_base + 4'h1;                                  // [RULE14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (sw_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  cnt_sat_a: assert property (cnt_q == tsc_pkg::CNT_MAX && hit && !clr_cnt && !sw_rst
                              |=> cnt_q == tsc_pkg::CNT_MAX) // [RULE14]
    else $error("event count left fifteen");

  rise_off_a: assert property (!cfg_q.rise_en && !clr_cnt && !sw_rst && !fall_ev
                               |=> cnt_q == $past(cnt_q)) // [RULE2]
    else $error("count moved with rising edges disabled");

  fall_off_a: assert property (!cfg_q.fall_en && !clr_cnt && !sw_rst && !rise_ev
                               |=> cnt_q == $past(cnt_q)) // [RULE3]
    else $error("count moved with falling edges disabled");

  // done toward downstream once a non-tail unit holds its two samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (sw_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= non_tail && (cnt_d >= tsc_pkg::CASC_MAX);       // [RULE4] [RULE6]
    end
  end

  assign casc_done_out = done_q;

  casc_done_a: assert property (non_tail && hit && cnt_q == 4'h1 && !clr_cnt && !sw_rst
                                ##1 non_tail |-> done_q ##1 !hit) // [RULE4] [RULE6]
    else $error("cascade done not raised after second event");

  //////////////////////////////////////////////////////////////////////////////
  // overflow flag; the set wins over a clear in the same cycle
  logic                 ovf_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
    end else if (sw_rst) begin
      ovf_q <= 1'b0;
    end else if (hit && cnt_base == tsc_pkg::CNT_MAX && !non_tail) begin
      ovf_q <= 1'b1;                                            // [RULE14]
    end else if (clr_ovf) begin
      ovf_q <= 1'b0;
    end
  end

  tail_ovf_a: assert property (non_tail && !ovf_q ##1 non_tail |-> !ovf_q) // [RULE14]
    else $error("non-tail cascade unit raised overflow");

  //////////////////////////////////////////////////////////////////////////////
  // sample slots; sub-cycle codes above four are stored as four
  tsc_pkg::tsc_sample_t smp1_q;
  tsc_pkg::tsc_sample_t smp2_q;
  tsc_pkg::tsc_sample_t smp_now;

  always_comb begin
    smp_now.rising = rise_ev;                                   // [RULE9]
    smp_now.t      = tod;                                       // [RULE16]
    if (tod.sub > tsc_pkg::SUB_MAX) begin
      smp_now.t.sub = tsc_pkg::SUB_MAX;                         // [RULE12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp1_q <= '0;
    end else if (sw_rst) begin
      smp1_q <= '0;
    end else if (hit && cnt_base == 4'h0) begin
      smp1_q <= smp_now;                                        // [RULE16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp2_q <= '0;
    end else if (sw_rst) begin
      smp2_q <= '0;
    end else if (hit && cnt_base == 4'h1) begin
      smp2_q <= smp_now;                                        // [RULE13] [RULE16]
    end
  end

  first_capt_a: assert property (hit && rise_ev && cnt_base == 4'h0 && !sw_rst
                                 |=> smp1_q.rising && smp1_q.t.ns == $past(tod.ns)
                                     && smp1_q.t.sec == $past(tod.sec)) // [RULE9]
    else $error("first sample not latched");

  second_capt_a: assert property (hit && cnt_base == 4'h1 && !sw_rst
                                  |=> smp2_q.t.ns == $past(tod.ns)
                                      && smp2_q.rising == $past(rise_ev)) // [RULE13]
    else $error("second sample not latched");

  sub_range_a: assert property (smp1_q.t.sub <= tsc_pkg::SUB_MAX
                                && smp2_q.t.sub <= tsc_pkg::SUB_MAX) // [RULE12]
    else $error("unused sub-cycle code stored");

  //////////////////////////////////////////////////////////////////////////////
  // read mux, registered in the setup cycle so prdata comes from flops
  logic [15:0]          rd_word;
  logic                 rd_hit;

  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = paddr[1:0] == 2'b00;
    unique case (idx)
      tsc_pkg::IDX_STATUS: rd_word = {11'h000, cnt_q, ovf_q};  // [RULE14]
      tsc_pkg::IDX_CONFIG: rd_word = {4'h0, cfg_q};
      tsc_pkg::IDX_CTRL:   rd_word = {15'h0000, en_q};
      tsc_pkg::IDX_S1_NSL: rd_word = sample_word(smp1_q, 3'h0); // [RULE7]
      tsc_pkg::IDX_S1_NSH: rd_word = sample_word(smp1_q, 3'h1); // [RULE8]
      tsc_pkg::IDX_S1_SL:  rd_word = sample_word(smp1_q, 3'h2); // [RULE10]
      tsc_pkg::IDX_S1_SH:  rd_word = sample_word(smp1_q, 3'h3); // [RULE11]
      tsc_pkg::IDX_S1_SUB: rd_word = sample_word(smp1_q, 3'h4); // [RULE12]
      tsc_pkg::IDX_S2_NSL: rd_word = sample_word(smp2_q, 3'h0); // [RULE13]
      tsc_pkg::IDX_S2_NSH: rd_word = sample_word(smp2_q, 3'h1);
      tsc_pkg::IDX_S2_SL:  rd_word = sample_word(smp2_q, 3'h2);
      tsc_pkg::IDX_S2_SH:  rd_word = sample_word(smp2_q, 3'h3);
      tsc_pkg::IDX_S2_SUB: rd_word = sample_word(smp2_q, 3'h4);
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= (rd_hit && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
      pslverr <= !rd_hit;
    end
  end

  // the edge bit is judged against the sample as it stood at the load edge,
  // since an event in the setup cycle may replace the first sample
  nsh_read_a: assert property (setup_ph && !pwrite && paddr == {tsc_pkg::IDX_S1_NSH, 2'b00}
                               |=> prdata[31:15] == 17'h00000
                                   && prdata[14] == $past(smp1_q.rising)) // [RULE8]
    else $error("high word reserved bits or edge wrong");

  sec_read_a: assert property (setup_ph && !pwrite && paddr == {tsc_pkg::IDX_S1_SL, 2'b00}
                               |=> prdata == {16'h0000, $past(smp1_q.t.sec[15:0])}) // [RULE10]
    else $error("seconds low word wrong");

  unmapped_a: assert property (setup_ph && paddr[1:0] != 2'b00 |=> pslverr) // [RULE7]
    else $error("misaligned access not refused");

  //////////////////////////////////////////////////////////////////////////////
  // further guards on flags and selection; each would catch a broken branch
  // that the register reads alone could miss between two status reads
  ovf_set_a: assert property (hit && cnt_base == tsc_pkg::CNT_MAX && !non_tail && !sw_rst
                              |=> ovf_q) // [RULE14]
    else $error("overflow not raised at saturation");

  cnt_clear_a: assert property (clr_cnt && !sw_rst && !hit |=> cnt_q == 4'h0) // [RULE14]
    else $error("enable write did not clear count");

  tail_done_a: assert property (!non_tail |=> !done_q) // [RULE4]
    else $error("tail or single unit raised done");

  pin_unused_a: assert property (cfg_q.pin_sel > tsc_pkg::PIN_SEL_MAX |-> !pin_now) // [RULE1]
    else $error("unused pin code selected a pin");

endmodule : tsc_capture_unit

// File: tb/tsc_event_src.sv
`timescale 1ns/100ps
module tsc_event_src (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [11:0]   gpio_req,
  output tsc_pkg::tsc_time_t tod,
  output logic      [11:0]   gpio_in
);
  ////////////////////////////////////////////////////////////////////////////
  // pins follow the request one edge later, like a registered outside driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gpio_in <= 12'h000;
    else gpio_in <= gpio_req;
  end

  // time of day: five 8 ns slots per 40 ns tick; starts 64 ticks before a second wrap,
  // which comes after the run ends, so the seconds words never change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod <= '{sec: 32'h0000_FFFF, ns: 30'h3B9A_C000, sub: 3'h0};
    end else if (tod.sub == 3'h4) begin
      tod.sub <= 3'h0;
      if (tod.ns >= 30'h3B9A_C9D8) begin
        tod.ns  <= 30'h0000_0000;
        tod.sec <= tod.sec + 32'h0000_0001;
      end else begin
        tod.ns <= tod.ns + 30'h0000_0028;
      end
    end else begin
      tod.sub <= tod.sub + 3'h1;
    end
  end
endmodule : tsc_event_src

// File: tb/timestamp_input_capture_unit_tb_top.sv
`timescale 1ns/100ps
module timestamp_input_capture_unit_tb_top;
  logic                  pclk         = 1'b0;
  logic                  presetn      = 1'b0;
  logic                  psel         = 1'b0;
  logic                  penable      = 1'b0;
  logic                  pwrite       = 1'b0;
  logic [15:0]           paddr        = 16'h0000;
  logic [31:0]           pwdata       = 32'h0000_0000;
  logic [11:0]           gpio_req     = 12'h000;
  logic [11:0]           casc_done_in = 12'h000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  casc_done_out;
  logic [11:0]           gpio_in;
  tsc_pkg::tsc_time_t    tod_w;
  tsc_pkg::tsc_sample_t  smp [3];
  tsc_pkg::tsc_cfg_t     cfg;
  logic [32:0]           expq [$];
  logic [32:0]           got_e;
  logic [31:0]           seed = 32'h0000_0056;
  int                    failures = 0;
  int                    samples_checked = 0;
  int                    p;
  localparam logic [13:0] RIDX [12] = '{tsc_pkg::IDX_STATUS, tsc_pkg::IDX_CONFIG,
    tsc_pkg::IDX_S1_NSL, tsc_pkg::IDX_S1_NSH, tsc_pkg::IDX_S1_SL, tsc_pkg::IDX_S1_SH,
    tsc_pkg::IDX_S1_SUB, tsc_pkg::IDX_S2_NSL, tsc_pkg::IDX_S2_NSH, tsc_pkg::IDX_S2_SL,
    tsc_pkg::IDX_S2_SH, tsc_pkg::IDX_S2_SUB};

  always #2 pclk = ~pclk;

  tsc_capture_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .tod(tod_w), .casc_done_in(casc_done_in),
    .casc_done_out(casc_done_out));
  tsc_event_src src (.pclk(pclk), .presetn(presetn), .gpio_req(gpio_req), .tod(tod_w),
    .gpio_in(gpio_in));

  //////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task check(input logic [32:0] e, input logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // request stays up after the access edge so back-to-back setups need no gap
  task apb(input logic w, input logic [13:0] ix, input logic [1:0] lo,
           input logic [31:0] d, input logic [32:0] e);
    expq.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {ix, lo};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
  endtask : apb

  task idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  task rd(input logic [13:0] ix, input logic [15:0] v);
    apb(1'b0, ix, 2'b00, 32'h0000_0000, {17'h00000, v});
  endtask : rd

  task wr(input logic [13:0] ix, input logic [15:0] v);
    apb(1'b1, ix, 2'b00, {16'h0000, v}, 33'h0_0000_0000);
  endtask : wr

  task arm(input tsc_pkg::tsc_cfg_t c);
    wr(tsc_pkg::IDX_CTRL, 16'h0002);
    wr(tsc_pkg::IDX_CONFIG, {4'h0, c});
    wr(tsc_pkg::IDX_CTRL, 16'h0001);
    idle();
  endtask : arm

  // one edge on a pin; the time of day is taken in the cycle the pin changes
  task ev(input int n, input int k);
    gpio_req[n] <= ~gpio_req[n];
    @(posedge pclk);
    @(negedge pclk);
    smp[k] = '{rising: gpio_in[n], t: tod_w};
    @(posedge pclk);
  endtask : ev

  task burst(input int n, input int cnt);
    repeat (cnt) begin
      gpio_req[n] <= ~gpio_req[n];
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask : burst

  task rd_smp(input logic [13:0] b, input tsc_pkg::tsc_sample_t s);
    rd(b, s.t.ns[15:0]);
    rd(b + 14'h2, {1'b0, s.rising, s.t.ns[29:16]});
    rd(b + 14'h4, s.t.sec[15:0]);
    rd(b + 14'h6, s.t.sec[31:16]);
    rd(b + 14'h8, {13'h0000, s.t.sub});
  endtask : rd_smp

  // every completed transfer takes the oldest note; writes judge pslverr only
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      got_e = expq.pop_front();
      if (pwrite) check({got_e[32], 32'h0}, {pslverr, 32'h0});
      else check(got_e, {pslverr, prdata});
    end
  end

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    conclude();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 12; i++) rd(RIDX[i], 16'h0000);
    apb(1'b0, 14'h0400, 2'b00, 32'h0, {1'b1, 32'h0}); // unmapped read refused
    apb(1'b1, tsc_pkg::IDX_CONFIG, 2'b10, 32'hFFF, {1'b1, 32'h0}); // misaligned
    wr(tsc_pkg::IDX_S1_NSL, 16'hFFFF);
    rd(tsc_pkg::IDX_S1_NSL, 16'h0000);
    rd(tsc_pkg::IDX_CONFIG, 16'h0000);
    // random pin, both edges, cascade off although upstream is not done
    p = int'(rnd() % 11);
    cfg = '{pin_sel: p[3:0], rise_en: 1'b1, fall_en: 1'b1, tail: 1'b1, up_sel: 4'h3,
           casc_en: 1'b0};
    arm(cfg);
    rd(tsc_pkg::IDX_CONFIG, {4'h0, cfg});
    idle();
    ev(p, 0);
    ev(p, 1);
    ev(p, 2);
    ev((p + 1) % 11, 2);
    rd(tsc_pkg::IDX_STATUS, 16'h0006);
    rd_smp(tsc_pkg::IDX_S1_NSL, smp[0]);
    rd_smp(tsc_pkg::IDX_S2_NSL, smp[1]);
    // one edge kind at a time on the top pin code
    for (int m = 0; m < 2; m++) begin
      cfg = '{pin_sel: 4'hB, rise_en: m[0], fall_en: !m[0], tail: 1'b0, up_sel: 4'h0,
             casc_en: 1'b0};
      arm(cfg);
      ev(11, 1 - m);
      ev(11, m);
      rd(tsc_pkg::IDX_STATUS, 16'h0002);
      rd_smp(tsc_pkg::IDX_S1_NSL, smp[0]);
    end
    // unused pin code sees nothing
    cfg.pin_sel = 4'hC;
    cfg.rise_en = 1'b1;
    cfg.fall_en = 1'b1;
    arm(cfg);
    burst(11, 2);
    rd(tsc_pkg::IDX_STATUS, 16'h0000);
    // cascade head as tail at full rate: saturate, then enable side effects
    cfg = '{pin_sel: 4'hB, rise_en: 1'b1, fall_en: 1'b1, tail: 1'b1, up_sel: 4'h0,
           casc_en: 1'b1};
    arm(cfg);
    burst(11, 17);
    rd(tsc_pkg::IDX_STATUS, 16'h001F);
    wr(tsc_pkg::IDX_CTRL, 16'h0001);
    rd(tsc_pkg::IDX_STATUS, 16'h0001);
    wr(tsc_pkg::IDX_CTRL, 16'h0000);
    rd(tsc_pkg::IDX_STATUS, 16'h0000);
    // non-tail head stops at two and raises done
    cfg.tail = 1'b0;
    arm(cfg);
    burst(11, 3);
    check(33'h1, {32'h0, casc_done_out});
    rd(tsc_pkg::IDX_STATUS, 16'h0004);
    // middle unit waits for its upstream done
    cfg.up_sel = 4'h3;
    arm(cfg);
    burst(11, 2);
    check(33'h0, {32'h0, casc_done_out});
    casc_done_in <= 12'h008;
    burst(11, 2);
    check(33'h1, {32'h0, casc_done_out});
    rd(tsc_pkg::IDX_STATUS, 16'h0004);
    idle();
    repeat (3) @(posedge pclk);
    conclude();
  end
endmodule : timestamp_input_capture_unit_tb_top
